// File: hdl/pcsu_core.v
// program counter, return stack, table pointer/latch and indirect addressing
`timescale 1ns/1ns
// Function
// - files 00h and 08h access memory at the address in pointer 01h or 09h
// - indirect read through a pointer holding 00h or 08h returns zero
// - indirect write through a pointer holding 00h or 08h is discarded
// - pointers increment, decrement or hold after each indirect access per status bits 7:4
// - files 0Dh and 0Eh form the 16-bit table address for table transfers
// - 16-bit table latch, unmapped, holds words moving between memories
// - 16-bit counter, low byte at file 02h, high byte not addressable
// - counter high holding latch at file 03h is the way to the high byte
// - counter increments at each fetch in the first quarter unless redirected
// - a taken skip advances the counter by two in total
// - long call loads high from holding latch, low from instruction bits 7:0
// - call or jump loads bits 12:0 and copies bits 15:13 into latch 7:5
// - reading counter low copies counter high into the holding latch
// - writing counter low loads it and loads the high byte from the latch
// - read-modify-write of counter low loads result, high from latch, latch kept
// - latch untouched by long call, returns and interrupt vector
// - 16x16 stack pushed on calls and interrupts, popped by returns
// - stack reachable only through push and pop
// - stack-available flag is 1 at reset, 0 when 16 held, 1 after pop
// - push on full stack loses oldest entry and clears flag until reset
// - pop from empty then push also clears the flag until reset
// - move between 00h and 08h transfers in one instruction cycle
// - latch write takes file data into low byte if select 0, else high
`include "pcsu_defs.vh"

module pcsu_core (
    input  wire        core_clk_i,
    input  wire        resetn_i,
    // quarter phase strobes
    input  wire        first_quarter_phase_i,
    input  wire        exec_strobe_i,
    // file access from the execution stage
    input  wire [7:0]  rd_addr_i,
    input  wire        rd_en_i,
    input  wire [7:0]  wr_addr_i,
    input  wire        wr_en_i,
    input  wire [7:0]  wr_data_i,
    input  wire        rmw_i,
    input  wire [7:0]  alu_status_reg_i,
    input  wire [7:0]  mem_rd_data_i,
    // counter control
    input  wire [2:0]  pc_op_i,
    input  wire [15:0] instruction_word_i,
    input  wire [15:0] vector_i,
    input  wire        skip_i,
    // table transfers
    input  wire        hold_write_instr_i,
    input  wire        hold_select_i,
    input  wire        table_read_instr_i,
    input  wire [15:0] prog_rd_data_i,
    // outputs
    output reg  [7:0]  rd_data_o,
    output reg  [7:0]  mem_rd_addr_o,
    output reg  [7:0]  mem_wr_addr_o,
    output reg         mem_wr_en_o,
    output reg  [7:0]  mem_wr_data_o,
    output reg  [15:0] prog_addr_o,
    output reg  [15:0] table_address_o,
    output reg  [15:0] table_hold_word_o,
    output reg         stack_available_flag_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function is_indirect;
        input [7:0] a;
        begin
            is_indirect = (a == `PCSU_F_INDIRECT_ZERO) || (a == `PCSU_F_INDIRECT_ONE);
        end
    endfunction

    function [7:0] step_ptr;
        input [7:0] p;
        input [1:0] mode;
        begin
            case (mode)
                `PCSU_MODE_DEC: step_ptr = p - 8'h01;
                `PCSU_MODE_INC: step_ptr = p + 8'h01;
                default:        step_ptr = p;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [7:0]  file_pointer_zero_q;
    reg [7:0]  file_pointer_one_q;
    reg [7:0]  hold_q;
    reg [15:0] pc_q;
    reg [7:0]  table_address_low_q;
    reg [7:0]  table_address_high_q;
    reg [7:0]  table_hold_low_q;
    reg [7:0]  table_hold_high_q;
    reg [15:0] stack_mem [0:`PCSU_STACK_DEPTH-1];
    reg [3:0]  stack_ptr_q;
    reg [4:0]  stack_count_q;
    reg        underflowed_q;
    reg        overflowed_q;

    // ----------------------------------------------------------------
    // indirect address resolution
    // ----------------------------------------------------------------
    wire       rd_ind     = is_indirect(rd_addr_i);
    wire       rd_use_one = (rd_addr_i == `PCSU_F_INDIRECT_ONE);
    wire [7:0] rd_target  = rd_ind ? (rd_use_one ? file_pointer_one_q : file_pointer_zero_q) : rd_addr_i;
    wire       rd_self    = rd_ind && is_indirect(rd_target);
    wire       wr_ind     = is_indirect(wr_addr_i);
    wire       wr_use_one = (wr_addr_i == `PCSU_F_INDIRECT_ONE);
    wire [7:0] wr_target  = wr_ind ? (wr_use_one ? file_pointer_one_q : file_pointer_zero_q) : wr_addr_i;
    wire       wr_self    = wr_ind && is_indirect(wr_target);
    // a write through a self-pointing pointer becomes a no-operation
    wire       wr_live    = exec_strobe_i && wr_en_i && !wr_self;

    // ----------------------------------------------------------------
    // read mux; pointers held at file addresses are served here
    // ----------------------------------------------------------------
    reg [7:0] rd_value;
    always @* begin
        if (rd_self) begin
            rd_value = `PCSU_ZERO8;
        end else begin
            case (rd_target)
                `PCSU_F_POINTER_ZERO: rd_value = file_pointer_zero_q;
                `PCSU_F_POINTER_ONE:  rd_value = file_pointer_one_q;
                `PCSU_F_COUNTER_LOW:  rd_value = pc_q[7:0];
                `PCSU_F_COUNTER_HOLD: rd_value = hold_q;
                `PCSU_F_TABLE_LOW:    rd_value = table_address_low_q;
                `PCSU_F_TABLE_HIGH:   rd_value = table_address_high_q;
                default:              rd_value = mem_rd_data_i;
            endcase
        end
    end

    // memory side is registered and follows one clock later, so a 00h/08h move reaches memory on the next cycle
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_o     <= `PCSU_ZERO8;
            mem_rd_addr_o <= `PCSU_ZERO8;
            mem_wr_addr_o <= `PCSU_ZERO8;
            mem_wr_en_o   <= 1'b0;
            mem_wr_data_o <= `PCSU_ZERO8;
        end else begin
            rd_data_o     <= rd_value;
            mem_rd_addr_o <= rd_target;
            mem_wr_addr_o <= wr_target;
            mem_wr_en_o   <= wr_live;
            mem_wr_data_o <= wr_data_i;
        end
    end

    // ----------------------------------------------------------------
    // file pointers
    // ----------------------------------------------------------------
    wire acc0 = exec_strobe_i && ((rd_en_i && rd_ind && !rd_use_one) || (wr_en_i && wr_ind && !wr_use_one));
    wire acc1 = exec_strobe_i && ((rd_en_i && rd_ind && rd_use_one) || (wr_en_i && wr_ind && wr_use_one));
    wire [1:0] mode0 = alu_status_reg_i[`PCSU_MODE0_LSB+1:`PCSU_MODE0_LSB];
    wire [1:0] mode1 = alu_status_reg_i[`PCSU_MODE1_LSB+1:`PCSU_MODE1_LSB];

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            file_pointer_zero_q <= `PCSU_ZERO8;
            file_pointer_one_q  <= `PCSU_ZERO8;
        end else begin
            // a direct write wins over the post-access step
            if (wr_live && wr_target == `PCSU_F_POINTER_ZERO) begin
                file_pointer_zero_q <= wr_data_i;
            end else if (acc0) begin
                file_pointer_zero_q <= step_ptr(file_pointer_zero_q, mode0);
            end
            if (wr_live && wr_target == `PCSU_F_POINTER_ONE) begin
                file_pointer_one_q <= wr_data_i;
            end else if (acc1) begin
                file_pointer_one_q <= step_ptr(file_pointer_one_q, mode1);
            end
        end
    end

    // ----------------------------------------------------------------
    // table pointer and table latch
    // ----------------------------------------------------------------
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            table_address_low_q  <= `PCSU_ZERO8;
            table_address_high_q <= `PCSU_ZERO8;
            table_hold_low_q     <= `PCSU_ZERO8;
            table_hold_high_q    <= `PCSU_ZERO8;
            table_address_o      <= `PCSU_ZERO16;
            table_hold_word_o    <= `PCSU_ZERO16;
        end else begin
            if (wr_live && wr_target == `PCSU_F_TABLE_LOW) begin
                table_address_low_q <= wr_data_i;
            end
            if (wr_live && wr_target == `PCSU_F_TABLE_HIGH) begin
                table_address_high_q <= wr_data_i;
            end
            if (exec_strobe_i && table_read_instr_i) begin
                table_hold_low_q  <= prog_rd_data_i[7:0];
                table_hold_high_q <= prog_rd_data_i[15:8];
            end else if (exec_strobe_i && hold_write_instr_i) begin
                if (hold_select_i) begin
                    table_hold_high_q <= rd_value;
                end else begin
                    table_hold_low_q <= rd_value;
                end
            end
            table_address_o   <= {table_address_high_q, table_address_low_q};
            table_hold_word_o <= {table_hold_high_q, table_hold_low_q};
        end
    end

    // ----------------------------------------------------------------
    // return stack; storage has no file address, only push and pop
    // ----------------------------------------------------------------
    wire do_push = exec_strobe_i && (pc_op_i == `PCSU_OP_CALL || pc_op_i == `PCSU_OP_LONG_CALL ||
                                     pc_op_i == `PCSU_OP_VECTOR);
    wire do_pop  = exec_strobe_i && (pc_op_i == `PCSU_OP_RETURN);
    wire [3:0]  top_idx = stack_ptr_q - `PCSU_ONE4;
    wire [15:0] top_val = stack_mem[top_idx];

    always @(posedge core_clk_i) begin
        if (do_push) begin
            stack_mem[stack_ptr_q] <= pc_q;
        end
    end

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stack_ptr_q            <= 4'h0;
            stack_count_q          <= 5'h00;
            underflowed_q          <= 1'b0;
            overflowed_q           <= 1'b0;
            stack_available_flag_o <= 1'b1;
        end else begin
            if (do_push) begin
                // pointer wraps, overwriting the oldest slot when full
                stack_ptr_q <= stack_ptr_q + `PCSU_ONE4;
                if (stack_count_q == `PCSU_STACK_FULL || underflowed_q) begin
                    overflowed_q <= 1'b1;
                end else begin
                    stack_count_q <= stack_count_q + `PCSU_ONE5;
                end
            end else if (do_pop) begin
                stack_ptr_q <= top_idx;
                if (stack_count_q == 5'h00) begin
                    underflowed_q <= 1'b1;
                end else begin
                    stack_count_q <= stack_count_q - `PCSU_ONE5;
                end
            end
            stack_available_flag_o <= !overflowed_q && !(do_push && (underflowed_q ||
                                       stack_count_q == `PCSU_STACK_FULL)) &&
                                      (do_pop ? 1'b1 : (do_push ? stack_count_q != `PCSU_STACK_FULL - `PCSU_ONE5
                                                                : stack_count_q != `PCSU_STACK_FULL));
        end
    end

    // ----------------------------------------------------------------
    // program counter and holding latch
    // ----------------------------------------------------------------
    reg [15:0] pc_d;
    reg [7:0]  hold_d;
    always @* begin
        pc_d   = pc_q;
        hold_d = hold_q;
        if (wr_live && wr_target == `PCSU_F_COUNTER_HOLD) begin
            hold_d = wr_data_i;
        end
        if (first_quarter_phase_i) begin
            pc_d = pc_q + (skip_i ? `PCSU_TWO16 : `PCSU_ONE16);
        end
        if (exec_strobe_i) begin
            if (rd_en_i && rd_target == `PCSU_F_COUNTER_LOW && !rmw_i) begin
                hold_d = pc_q[15:8];
            end
            case (pc_op_i)
                `PCSU_OP_CALL, `PCSU_OP_GOTO: begin
                    pc_d = {pc_q[15:`PCSU_JUMP_MSB+1], instruction_word_i[`PCSU_JUMP_MSB:0]};
                    hold_d[7:`PCSU_HOLD_PAGE_LSB] = pc_q[15:`PCSU_JUMP_MSB+1];
                end
                `PCSU_OP_LONG_CALL: pc_d = {hold_q, instruction_word_i[7:0]};
                `PCSU_OP_RETURN:    pc_d = top_val;
                `PCSU_OP_VECTOR:    pc_d = vector_i;
                default: begin
                    if (wr_live && wr_target == `PCSU_F_COUNTER_LOW) begin
                        pc_d   = {hold_q, wr_data_i};
                        hold_d = hold_q;
                    end
                end
            endcase
        end
    end

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc_q        <= `PCSU_RESET_VECTOR;
            hold_q      <= `PCSU_ZERO8;
            prog_addr_o <= `PCSU_RESET_VECTOR;
        end else begin
            pc_q        <= pc_d;
            hold_q      <= hold_d;
            prog_addr_o <= pc_d;
        end
    end

endmodule

// File: hdl/pcsu_defs.vh
// constants for the program-counter, stack and indirect addressing unit
`ifndef PCSU_DEFS_VH
`define PCSU_DEFS_VH

// ----------------------------------------------------------------
// file addresses
// ----------------------------------------------------------------
`define PCSU_F_INDIRECT_ZERO   8'h00
`define PCSU_F_POINTER_ZERO    8'h01
`define PCSU_F_COUNTER_LOW     8'h02
`define PCSU_F_COUNTER_HOLD    8'h03
`define PCSU_F_INDIRECT_ONE    8'h08
`define PCSU_F_POINTER_ONE     8'h09
`define PCSU_F_TABLE_LOW       8'h0D
`define PCSU_F_TABLE_HIGH      8'h0E

// ----------------------------------------------------------------
// pointer mode fields in alu_status_reg bits 7:4
// ----------------------------------------------------------------
`define PCSU_MODE0_LSB         4
`define PCSU_MODE1_LSB         6
`define PCSU_MODE_DEC          2'b00
`define PCSU_MODE_INC          2'b01

// ----------------------------------------------------------------
// counter fields and widths
// ----------------------------------------------------------------
`define PCSU_JUMP_MSB          12
`define PCSU_HOLD_PAGE_LSB     5
`define PCSU_STACK_DEPTH       16
`define PCSU_STACK_FULL        5'h10
`define PCSU_RESET_VECTOR      16'h0000
`define PCSU_ZERO8             8'h00
`define PCSU_ZERO16            16'h0000
`define PCSU_ONE16             16'h0001
`define PCSU_TWO16             16'h0002
`define PCSU_ONE5              5'h01
`define PCSU_ONE4              4'h1

// ----------------------------------------------------------------
// counter operation codes
// ----------------------------------------------------------------
`define PCSU_OP_NONE           3'd0
`define PCSU_OP_CALL           3'd1
`define PCSU_OP_GOTO           3'd2
`define PCSU_OP_LONG_CALL      3'd3
`define PCSU_OP_RETURN         3'd4
`define PCSU_OP_VECTOR         3'd5

`endif

// File: verification/pcsu_core_sva.sv
// port assertions for the counter, stack and pointer unit
`timescale 1ns/1ns
module pcsu_core_sva (
    input wire        core_clk_i,
    input wire        resetn_i,
    input wire        first_quarter_phase_i,
    input wire        exec_strobe_i,
    input wire [7:0]  rd_addr_i,
    input wire        rd_en_i,
    input wire [7:0]  wr_addr_i,
    input wire        wr_en_i,
    input wire [7:0]  wr_data_i,
    input wire [2:0]  pc_op_i,
    input wire [15:0] instruction_word_i,
    input wire        skip_i,
    input wire [7:0]  rd_data_o,
    input wire        mem_wr_en_o,
    input wire [15:0] prog_addr_o,
    input wire        stack_available_flag_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // ----------------------------------------------------------------
    // previous-cycle causes
    // ----------------------------------------------------------------
    reg wr_q;
    reg push_q;
    reg pop_q;
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {wr_q, push_q, pop_q} <= 3'b000;
        end else begin
            // every live file write reaches data memory, direct ones too
            wr_q     <= exec_strobe_i && wr_en_i;
            push_q   <= exec_strobe_i && (pc_op_i == 3'd1 || pc_op_i == 3'd3 || pc_op_i == 3'd5);
            pop_q    <= exec_strobe_i && pc_op_i == 3'd4;
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_RESET: assert property (disable iff (1'b0) !resetn_i |->
        prog_addr_o == 16'h0000 && stack_available_flag_o)
        else $error("reset values wrong");
    AST_STEP: assert property (first_quarter_phase_i && !exec_strobe_i && !skip_i |=>
        prog_addr_o == $past(prog_addr_o) + 16'h0001)
        else $error("counter did not step by one");
    AST_SKIP: assert property (first_quarter_phase_i && !exec_strobe_i && skip_i |=>
        prog_addr_o == $past(prog_addr_o) + 16'h0002)
        else $error("skip did not step by two");
    AST_LOW_WRITE: assert property (exec_strobe_i && wr_en_i && wr_addr_i == 8'h02 && pc_op_i == 3'd0 |=>
        prog_addr_o[7:0] == $past(wr_data_i))
        else $error("counter low not loaded");
    AST_JUMP: assert property (exec_strobe_i && (pc_op_i == 3'd1 || pc_op_i == 3'd2) |=>
        (prog_addr_o & 16'h1fff) == ($past(instruction_word_i) & 16'h1fff) &&
        (prog_addr_o & 16'he000) == ($past(prog_addr_o) & 16'he000))
        else $error("jump target wrong");
    AST_LONG_CALL: assert property (exec_strobe_i && pc_op_i == 3'd3 |=>
        {8'h00, prog_addr_o[7:0]} == ($past(instruction_word_i) & 16'h00ff))
        else $error("long call low byte wrong");
    AST_LOW_READ: assert property (exec_strobe_i && rd_en_i && rd_addr_i == 8'h02 && !first_quarter_phase_i
        |=> {8'h00, rd_data_o} == ($past(prog_addr_o) & 16'h00ff))
        else $error("counter low read wrong");
    AST_WR_CAUSE: assert property (mem_wr_en_o |-> wr_q)
        else $error("memory write without file write");
    AST_FLAG_RISE: assert property ($rose(stack_available_flag_o) |-> pop_q)
        else $error("flag set without pop");
    AST_FLAG_FALL: assert property ($fell(stack_available_flag_o) |-> push_q)
        else $error("flag cleared without push");
    COV_OVERFLOW: cover property (push_q && !stack_available_flag_o);
    COV_SKIP: cover property (first_quarter_phase_i && skip_i);
    COV_IND_WRITE: cover property (mem_wr_en_o);
endmodule
bind pcsu_core pcsu_core_sva i_pcsu_core_sva (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .first_quarter_phase_i(first_quarter_phase_i), .exec_strobe_i(exec_strobe_i), .rd_addr_i(rd_addr_i),
    .rd_en_i(rd_en_i), .wr_addr_i(wr_addr_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .pc_op_i(pc_op_i),
    .instruction_word_i(instruction_word_i), .skip_i(skip_i), .rd_data_o(rd_data_o), .mem_wr_en_o(mem_wr_en_o),
    .prog_addr_o(prog_addr_o), .stack_available_flag_o(stack_available_flag_o));

// File: verification/pcsu_mem_model.sv
// data memory model behind the resolved indirect addresses
`timescale 1ns/1ns
module pcsu_mem_model (
    input  wire       core_clk_i,
    input  wire [7:0] rd_addr_i,
    input  wire [7:0] wr_addr_i,
    input  wire       wr_en_i,
    input  wire [7:0] wr_data_i,
    output wire [7:0] rd_data_o
);
    reg [7:0] mem_q [0:255];
    reg       vld_q [0:255];
    integer   i;
    initial for (i = 0; i < 256; i = i + 1) vld_q[i] = 1'b0;
    // unwritten cells give a per-address pattern, address XOR A5h, zero only at A5h
    assign rd_data_o = vld_q[rd_addr_i] ? mem_q[rd_addr_i] : rd_addr_i ^ 8'ha5;
    always @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
            vld_q[wr_addr_i] <= 1'b1;
        end
    end
endmodule

// File: verification/pcsu_core_test.sv
// self-checking bench for the counter, stack and pointer unit
`timescale 1ns/1ns
module pcsu_core_test;
    typedef struct { int k; logic [15:0] v; } pcsu_note_t;
    logic        clk, rstn, fq, ex, rde, wre, rmw, skip, hw, hs, tr, mwe, flag;
    logic [7:0]  rda, wra, wrd, alu, mrd, rdo, mra, mwa, mwd, hh;
    logic [2:0]  op;
    logic [15:0] iw, vec, prd, pa, ta, th, pc, t;
    logic [15:0] stk[$];
    pcsu_note_t  q[$];
    pcsu_note_t  nt;
    int          fails, checked, i;
    event        chk;
    pcsu_core i_pcsu_core (.core_clk_i(clk), .resetn_i(rstn), .first_quarter_phase_i(fq), .exec_strobe_i(ex),
        .rd_addr_i(rda), .rd_en_i(rde), .wr_addr_i(wra), .wr_en_i(wre), .wr_data_i(wrd), .rmw_i(rmw),
        .alu_status_reg_i(alu), .mem_rd_data_i(mrd), .pc_op_i(op), .instruction_word_i(iw), .vector_i(vec),
        .skip_i(skip), .hold_write_instr_i(hw), .hold_select_i(hs), .table_read_instr_i(tr),
        .prog_rd_data_i(prd), .rd_data_o(rdo), .mem_rd_addr_o(mra), .mem_wr_addr_o(mwa), .mem_wr_en_o(mwe),
        .mem_wr_data_o(mwd), .prog_addr_o(pa), .table_address_o(ta), .table_hold_word_o(th),
        .stack_available_flag_o(flag));
    pcsu_mem_model i_pcsu_mem_model (.core_clk_i(clk), .rd_addr_i(mra), .wr_addr_i(mwa), .wr_en_i(mwe),
        .wr_data_i(mwd), .rd_data_o(mrd));
    always #4 clk = ~clk;
    // ----------------------------------------------------------------
    // checking side
    // ----------------------------------------------------------------
    task cmp16(input string n, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp16(n, {8'h00, e}, {8'h00, s});
    endtask
    task cmp1(input string n, input logic e, input logic s);
        cmp16(n, {15'h0000, e}, {15'h0000, s});
    endtask
    always @(chk) begin
        while (q.size() > 0) begin
            nt = q.pop_front();
            case (nt.k)
                0: cmp16("prog_addr_o", nt.v, pa);
                1: cmp8("rd_data_o", nt.v[7:0], rdo);
                2: cmp1("stack_available_flag_o", nt.v[0], flag);
                3: cmp16("table_address_o", nt.v, ta);
                4: cmp16("table_hold_word_o", nt.v, th);
                5: cmp8("mem_wr_addr_o", nt.v[7:0], mwa);
                6: cmp1("mem_wr_en_o", nt.v[0], mwe);
                8: cmp8("mem_wr_data_o", nt.v[7:0], mwd);
                default: cmp8("mem_rd_addr_o", nt.v[7:0], mra);
            endcase
        end
    end
    task note(input int k, input logic [15:0] v);
        q.push_back('{k, v});
        ->chk;
    endtask
    task summarize();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // driving side
    // ----------------------------------------------------------------
    task go(input logic [2:0] o, input logic [15:0] w, input logic we, input logic [7:0] wa, input logic [7:0] d,
            input logic re, input logic [7:0] ra, input logic [3:0] x);
        @(negedge clk);
        {ex, op, iw, wre, wra, wrd, rde, rda, rmw, tr, hw, hs} = {1'b1, o, w, we, wa, d, re, ra, x};
        @(negedge clk);
        {ex, op, wre, rde, rmw, tr, hw, hs} = '0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        go(3'd0, 16'h0000, 1'b1, a, d, 1'b0, 8'h00, 4'h0);
    endtask
    task rd(input logic [7:0] a);
        go(3'd0, 16'h0000, 1'b0, 8'h00, 8'h00, 1'b1, a, 4'h0);
    endtask
    task step(input logic s);
        @(negedge clk);
        {fq, skip} = {1'b1, s};
        @(negedge clk);
        {fq, skip} = 2'b00;
    endtask
    task push(input logic [2:0] o, input logic [15:0] w);
        go(o, w, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, 4'h0);
        stk.push_back(pc);
        if (stk.size() > 16) void'(stk.pop_front());
    endtask
    task pop();
        go(3'd4, 16'h0000, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, 4'h0);
        if (stk.size() > 0) begin
            pc = stk.pop_back();
            note(0, pc);
        end
    endtask
    task callj();
        t = $urandom;
        hh = {pc[15:13], hh[4:0]};
        push(3'd1, t);
        pc = {pc[15:13], t[12:0]};
        note(0, pc);
    endtask
    task rst();
        // lets pending compares see the outputs before they are reset
        @(negedge clk);
        rstn = 0;
        repeat (16) @(negedge clk);
        rstn = 1;
        {pc, hh} = 0;
        stk.delete();
        note(2, 16'h0001);
    endtask
    initial begin
        {clk, fq, ex, rde, wre, rmw, skip, hw, hs, tr, rda, wra, wrd, alu, op, iw, vec, prd} = '0;
        // reset falls later on a clean edge, not as a time-zero race
        rstn = 1'b1;
        i = $urandom(62);
        rst();
        note(0, 16'h0000);
        note(3, 16'h0000);
        $display("reset values done");
        t = $urandom;
        wr(8'h03, t[7:0]);
        wr(8'h02, t[15:8]);
        pc = {t[7:0], t[15:8]};
        note(0, pc);
        step(1'b0);
        note(0, pc + 16'h0001);
        step(1'b1);
        pc = pc + 16'h0003;
        note(0, pc);
        hh = t[7:0];
        callj();
        pop();
        rd(8'h03);
        note(1, {pc[15:13], hh[4:0]});
        rd(8'h02);
        note(1, pc[7:0]);
        rd(8'h03);
        note(1, pc[15:8]);
        t = $urandom;
        wr(8'h03, t[7:0]);
        go(3'd0, 16'h0000, 1'b1, 8'h02, t[15:8], 1'b1, 8'h02, 4'h8);
        pc = {t[7:0], t[15:8]};
        hh = t[7:0];
        note(0, pc);
        rd(8'h03);
        note(1, hh);
        $display("counter loads done");
        t = $urandom;
        push(3'd3, t);
        pc = {hh, t[7:0]};
        note(0, pc);
        pop();
        vec = $urandom;
        push(3'd5, 16'h0000);
        pc = vec;
        note(0, pc);
        pop();
        rd(8'h03);
        note(1, hh);
        $display("calls and returns done");
        for (i = 0; i < 16; i++) begin
            callj();
            note(2, i < 15);
        end
        pop();
        note(2, 16'h0001);
        callj();
        callj();
        note(2, 16'h0000);
        for (i = 0; i < 16; i++) pop();
        note(2, 16'h0000);
        rst();
        pop();
        wr(8'h03, 8'h00);
        wr(8'h02, 8'h00);
        callj();
        pop();
        note(2, 16'h0000);
        rst();
        $display("stack flag done");
        alu = 8'h90;
        wr(8'h01, 8'h40);
        wr(8'h00, 8'h5a);
        note(6, 16'h0001);
        note(8, 16'h005a);
        note(5, 16'h0040);
        wr(8'h00, 8'h5b);
        note(5, 16'h0041);
        alu = 8'h80;
        wr(8'h00, 8'h5c);
        note(5, 16'h0042);
        wr(8'h00, 8'h5d);
        note(5, 16'h0041);
        wr(8'h09, 8'h08);
        wr(8'h08, 8'h77);
        note(6, 16'h0000);
        rd(8'h08);
        note(1, 16'h0000);
        wr(8'h09, 8'h50);
        go(3'd0, 16'h0000, 1'b1, 8'h08, 8'h00, 1'b1, 8'h00, 4'h0);
        note(7, 16'h0040);
        note(5, 16'h0050);
        $display("indirect access done");
        t = $urandom;
        wr(8'h0d, t[7:0]);
        wr(8'h0e, t[15:8]);
        @(negedge clk);
        note(3, t);
        prd = $urandom;
        go(3'd0, 16'h0000, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, 4'h4);
        @(negedge clk);
        note(4, prd);
        go(3'd0, 16'h0000, 1'b0, 8'h00, t[7:0], 1'b1, 8'h0d, 4'h3);
        @(negedge clk);
        note(4, {t[7:0], prd[7:0]});
        go(3'd0, 16'h0000, 1'b0, 8'h00, 8'h00, 1'b1, 8'h0e, 4'h2);
        @(negedge clk);
        note(4, {t[7:0], t[15:8]});
        $display("table transfers done");
        #1;
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule
